// ---- verilog/obc_ctrl.sv ----
// main-board side of the option bus: cycles, arbitration, clocks, resets
`include "obc_map.svh"
`default_nettype none
// What this block does
// - memory write strobe low on memory writes
// - memory read strobe low on memory reads
// - io strobes only for main processor
// - memory/io select stable before latch strobe falls
// - early memory trigger on every memory and refresh cycle, main processor or not
// - latch strobe pulses only for main cycles
// - 8 MHz bus clock driven out
// - byte lane encoding from upper enable, a0
// - shared wait line stretches the cycle
// - two waits for io 300 to 3ff
// - system io select for io below 400
// - irq lines map to fixed vector types
// - grant after cycle ends, not locked
// - refresh cycle asserts refresh, rotating address
// - parity fail raises nmi, records source
// - free running 2.458 MHz baud clock
// - global reset on power, button, key combo
// - video syncs and clocks driven out
// - twenty address lines, 1 MByte
// - upper byte lane enabled on wide cycles
module obc_ctrl
  import obc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire obc_req_s    cpu_req,
  output logic             cpu_ready,
  input  wire logic        onboard_parity_err,
  input  wire logic        reset_button,
  input  wire logic        key_reset_combo,
  input  wire logic [6:0]  expansion_irq_line_n,
  input  wire logic [3:0]  bus_master_request_n,
  input  wire logic        wait_request_n_in,
  input  wire logic        parity_error_n,
  output logic [3:0]       bus_master_grant_n,
  output logic             bus_owned,
  output logic [19:0]      bus_address_line,
  output logic             bus_address_oe,
  output logic             upper_byte_lane_enable_n,
  output logic             mem_write_strobe_n,
  output logic             mem_read_strobe_n,
  output logic             mem_strobe_oe,
  output logic             io_write_strobe_n,
  output logic             io_read_strobe_n,
  output logic             mem_not_io_select,
  output logic             early_mem_cycle_trigger_n,
  output logic             address_latch_strobe,
  output logic             wait_request_n_out,
  output logic             wait_request_oe,
  output logic             system_io_page_select_n,
  output logic             dram_refresh_cycle_n,
  output logic             nmi,
  output logic             parity_offboard,
  output logic             irq_valid,
  output logic [7:0]       irq_vector,
  output logic             bus_clock,
  output logic             serial_rate_clock,
  output logic             global_reset_n,
  output logic             dot_clock_n,
  output logic             character_clock_n,
  output logic             hsync_n,
  output logic             vsync_n
);
  obc_state_e  st_reg, st_next;
  obc_req_s    cur_reg, cur_next;
  logic [2:0]  wcnt_reg, wcnt_next;
  logic [7:0]  rfa_reg, rfa_next;
  logic [3:0]  gnt_reg, gnt_next;
  logic        rdy_reg, rdy_next;
  logic        ale_reg, ale_next, smc_reg, smc_next, mrd_reg, mrd_next, mwr_reg, mwr_next;
  logic        ird_reg, ird_next, iwr_reg, iwr_next, mio_reg, mio_next, sio_reg, sio_next;
  logic        ube_reg, ube_next, ref_reg, ref_next, aoe_reg, aoe_next;
  logic [19:0] adr_reg, adr_next;
  logic        slow_io, sys_io;

  assign sys_io  = !cur_reg.is_mem && cur_reg.addr <= `OBC_SYS_IO_HI;
  assign slow_io = !cur_reg.is_mem && cur_reg.addr >= `OBC_SLOW_IO_LO && cur_reg.addr <= `OBC_SLOW_IO_HI;

  always_comb begin
    st_next = st_reg; cur_next = cur_reg; wcnt_next = wcnt_reg; rfa_next = rfa_reg;
    gnt_next = gnt_reg; rdy_next = 1'b0; ale_next = 1'b0; smc_next = 1'b1;
    mrd_next = mrd_reg; mwr_next = mwr_reg; ird_next = ird_reg; iwr_next = iwr_reg;
    mio_next = mio_reg; sio_next = sio_reg; ube_next = ube_reg; ref_next = ref_reg;
    adr_next = adr_reg; aoe_next = aoe_reg;
    unique case (st_reg)
      OBC_IDLE: begin
        // a locked sequence holds masters off until the cpu lets go of the bus
        if (bus_master_request_n != 4'hf && !(cur_reg.locked && cpu_req.valid)) begin
          // lowest index wins; outside a locked sequence a request only waits for the current cycle
          gnt_next = 4'h0;
          for (int i = 3; i >= 0; i--) begin
            if (!bus_master_request_n[i]) gnt_next = 4'(1 << i);
          end
          aoe_next = 1'b0;
          cur_next.locked = 1'b0;
          st_next  = OBC_GRANT;
        end else if (cpu_req.valid) begin
          cur_next = cpu_req;
          adr_next = cpu_req.refresh ? {12'h000, rfa_reg} : cpu_req.addr;
          mio_next = cpu_req.is_mem || cpu_req.refresh;
          ube_next = !cpu_req.wide;
          ale_next = cpu_req.main_cpu && !cpu_req.refresh;
          aoe_next = 1'b1;
          st_next  = OBC_ALE;
        end
      end
      OBC_ALE: begin
        // io strobes are refused for anything but the main processor
        ird_next = !(!cur_reg.is_mem && !cur_reg.refresh && !cur_reg.write && cur_reg.main_cpu);
        iwr_next = !(!cur_reg.is_mem && !cur_reg.refresh && cur_reg.write && cur_reg.main_cpu);
        mrd_next = !((cur_reg.is_mem && !cur_reg.write) || cur_reg.refresh);
        mwr_next = !(cur_reg.is_mem && cur_reg.write && !cur_reg.refresh);
        smc_next = !(cur_reg.is_mem || cur_reg.refresh);
        sio_next = !sys_io;
        ref_next = !cur_reg.refresh;
        wcnt_next = slow_io ? `OBC_IO_WAITS : 3'd0;
        st_next  = OBC_STRB;
      end
      OBC_STRB, OBC_WAIT: begin
        if (wcnt_reg != 3'd0) begin
          wcnt_next = wcnt_reg - 3'd1;
          st_next   = OBC_WAIT;
        end else if (wait_request_n_in) begin
          st_next = OBC_DONE;
        end
      end
      OBC_DONE: begin
        {mrd_next, mwr_next, ird_next, iwr_next, sio_next, ref_next} = 6'h3f;
        if (cur_reg.refresh) rfa_next = rfa_reg + 8'd1;
        rdy_next = !cur_reg.refresh;
        // a locked sequence keeps the bus until its last cycle
        if (!cur_reg.locked || cur_reg.refresh) aoe_next = 1'b0;
        cur_next.valid = 1'b0;
        st_next  = OBC_IDLE;
      end
      OBC_GRANT: begin
        if ((gnt_reg & ~bus_master_request_n) == 4'h0) begin
          gnt_next = 4'h0;
          st_next  = OBC_IDLE;
        end
      end
      default: st_next = OBC_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_reg <= OBC_IDLE; cur_reg <= '0; wcnt_reg <= 3'd0; rfa_reg <= 8'h00; gnt_reg <= 4'h0;
      rdy_reg <= 1'b0; ale_reg <= 1'b0; smc_reg <= 1'b1; mrd_reg <= 1'b1; mwr_reg <= 1'b1;
      ird_reg <= 1'b1; iwr_reg <= 1'b1; mio_reg <= 1'b1; sio_reg <= 1'b1; ube_reg <= 1'b1;
      ref_reg <= 1'b1; adr_reg <= 20'h0; aoe_reg <= 1'b0;
    end else begin
      st_reg <= st_next; cur_reg <= cur_next; wcnt_reg <= wcnt_next; rfa_reg <= rfa_next;
      gnt_reg <= gnt_next; rdy_reg <= rdy_next; ale_reg <= ale_next; smc_reg <= smc_next;
      mrd_reg <= mrd_next; mwr_reg <= mwr_next; ird_reg <= ird_next; iwr_reg <= iwr_next;
      mio_reg <= mio_next; sio_reg <= sio_next; ube_reg <= ube_next; ref_reg <= ref_next;
      adr_reg <= adr_next; aoe_reg <= aoe_next;
    end
  end

  assign cpu_ready                 = rdy_reg;
  assign bus_master_grant_n        = ~gnt_reg;
  assign bus_owned                 = aoe_reg;
  assign bus_address_line          = adr_reg;
  assign bus_address_oe            = aoe_reg;
  assign mem_strobe_oe             = aoe_reg;
  assign upper_byte_lane_enable_n  = ube_reg;
  assign mem_write_strobe_n        = mwr_reg;
  assign mem_read_strobe_n         = mrd_reg;
  assign io_write_strobe_n         = iwr_reg;
  assign io_read_strobe_n          = ird_reg;
  assign mem_not_io_select         = mio_reg;
  assign early_mem_cycle_trigger_n = smc_reg;
  assign address_latch_strobe      = ale_reg;
  assign system_io_page_select_n   = sio_reg;
  assign dram_refresh_cycle_n      = ref_reg;
  // the main board never pulls the shared wait line itself; its own waits are internal
  assign wait_request_n_out        = 1'b1;
  assign wait_request_oe           = 1'b0;

  // parity: nmi latched until reset, source recorded
  logic nmi_reg, nmi_next, off_reg, off_next;
  always_comb begin
    // only the first failure is recorded; later ones are lost until reset
    nmi_next = nmi_reg;
    off_next = off_reg;
    if (!nmi_reg && (!parity_error_n || onboard_parity_err)) begin
      nmi_next = 1'b1;
      off_next = !parity_error_n;
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      nmi_reg <= 1'b0; off_reg <= 1'b0;
    end else begin
      nmi_reg <= nmi_next; off_reg <= off_next;
    end
  end
  assign nmi             = nmi_reg;
  assign parity_offboard = off_reg;

  // irq lines: fixed vector per line, lowest line first
  logic       iv_reg, iv_next;
  logic [7:0] vec_reg, vec_next;
  localparam logic [7:0] IRQ_NUM [7] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h06, 8'h09, 8'h0b};
  always_comb begin
    iv_next  = 1'b0;
    vec_next = vec_reg;
    for (int i = 6; i >= 0; i--) begin
      if (!expansion_irq_line_n[i]) begin
        iv_next  = 1'b1;
        vec_next = (IRQ_NUM[i] > 8'h06) ? (`OBC_VEC_SLAVE | IRQ_NUM[i]) : (`OBC_VEC_BASE | IRQ_NUM[i]);
      end
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      iv_reg <= 1'b0; vec_reg <= 8'h00;
    end else begin
      iv_reg <= iv_next; vec_reg <= vec_next;
    end
  end
  assign irq_valid  = iv_reg;
  assign irq_vector = vec_reg;

  // clock dividers; baud rounds to nearest whole half period
  logic [4:0]  bc_reg, bc_next, dc_reg, dc_next;
  logic [6:0]  ac_reg, ac_next;
  logic [3:0]  cc_reg, cc_next;
  logic [7:0]  hc_reg, hc_next, rc_reg, rc_next;
  logic [9:0]  vc_reg, vc_next;
  logic        bclk_reg, bclk_next, aclk_reg, aclk_next, dclk_reg, dclk_next, cclk_reg, cclk_next;
  logic        hs_reg, hs_next, vs_reg, vs_next, grn_reg, grn_next;
  always_comb begin
    // bus clock half period truncates, so the bus clock runs a little fast
    bc_next = bc_reg + 5'd1; bclk_next = bclk_reg;
    if (bc_reg == 5'(`OBC_BUS_CLK_HALF - 1)) begin
      bc_next = 5'd0; bclk_next = !bclk_reg;
    end
    ac_next = ac_reg + 7'd1; aclk_next = aclk_reg;
    if (ac_reg == 7'(`OBC_BAUD_HALF - 1)) begin
      ac_next = 7'd0; aclk_next = !aclk_reg;
    end
    dc_next = dc_reg + 5'd1; dclk_next = dclk_reg;
    cc_next = cc_reg; cclk_next = cclk_reg; hc_next = hc_reg; hs_next = hs_reg;
    vc_next = vc_reg; vs_next = vs_reg;
    if (dc_reg == `OBC_DOT_HALF - 5'd1) begin
      dc_next = 5'd0; dclk_next = !dclk_reg;
      if (dclk_reg) begin
        cc_next = cc_reg + 4'd1;
        if (cc_reg == `OBC_CHAR_DOTS - 4'd1) begin
          cc_next = 4'd0; hc_next = hc_reg + 8'd1;
          if (hc_reg == `OBC_HSYNC_CHARS - 8'd1) begin
            hc_next = 8'd0; vc_next = vc_reg + 10'd1;
            if (vc_reg == `OBC_VSYNC_LINES - 10'd1) vc_next = 10'd0;
          end
        end
        cclk_next = (cc_next >= (`OBC_CHAR_DOTS >> 1));
        hs_next   = (hc_next < `OBC_HSYNC_WIDTH);
        vs_next   = (vc_next < `OBC_VSYNC_WIDTH);
      end
    end
    // reset held a short fixed time, retriggered by button or key combo
    rc_next = rc_reg; grn_next = grn_reg;
    if (reset_button || key_reset_combo) begin
      rc_next = 8'd0; grn_next = 1'b0;
    end else if (rc_reg != `OBC_RST_CYCLES) begin
      rc_next = rc_reg + 8'd1; grn_next = 1'b0;
    end else begin
      grn_next = 1'b1;
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bc_reg <= 5'd0; ac_reg <= 7'd0; dc_reg <= 5'd0; cc_reg <= 4'd0; hc_reg <= 8'd0;
      vc_reg <= 10'd0; rc_reg <= 8'd0; bclk_reg <= 1'b0; aclk_reg <= 1'b0; dclk_reg <= 1'b0;
      cclk_reg <= 1'b0; hs_reg <= 1'b0; vs_reg <= 1'b0; grn_reg <= 1'b0;
    end else begin
      bc_reg <= bc_next; ac_reg <= ac_next; dc_reg <= dc_next; cc_reg <= cc_next; hc_reg <= hc_next;
      vc_reg <= vc_next; rc_reg <= rc_next; bclk_reg <= bclk_next; aclk_reg <= aclk_next;
      dclk_reg <= dclk_next; cclk_reg <= cclk_next; hs_reg <= hs_next; vs_reg <= vs_next;
      grn_reg <= grn_next;
    end
  end
  assign bus_clock         = bclk_reg;
  assign serial_rate_clock = aclk_reg;
  assign dot_clock_n       = dclk_reg;
  assign character_clock_n = !cclk_reg;
  assign hsync_n           = !hs_reg;
  assign vsync_n           = !vs_reg;
  assign global_reset_n    = grn_reg;
endmodule
`default_nettype wire

// ---- shared/obc_map.svh ----
// constants for the option bus controller
`ifndef OBC_MAP_SVH
`define OBC_MAP_SVH
`define OBC_CLK_HZ          250000000
`define OBC_BUS_CLK_HZ      8000000
`define OBC_BUS_CLK_HALF    ((`OBC_CLK_HZ / `OBC_BUS_CLK_HZ) / 2)
`define OBC_BAUD_HZ_X1000   64'd2458000000
`define OBC_BAUD_HALF       ((`OBC_CLK_HZ * 64'd1000 + `OBC_BAUD_HZ_X1000) / (`OBC_BAUD_HZ_X1000 * 2))
`define OBC_DOT_HALF        5'd2
`define OBC_CHAR_DOTS       4'd8
`define OBC_HSYNC_CHARS     8'd100
`define OBC_VSYNC_LINES     10'd312
`define OBC_HSYNC_WIDTH     8'd8
`define OBC_VSYNC_WIDTH     10'd3
`define OBC_SLOW_IO_LO      20'h00300
`define OBC_SLOW_IO_HI      20'h003ff
`define OBC_SYS_IO_HI       20'h003ff
`define OBC_IO_WAITS        3'd2
`define OBC_RST_CYCLES      8'd64
`define OBC_VEC_BASE        8'h60
`define OBC_VEC_SLAVE       8'h68
`define OBC_REFRESH_MOD     8'hff
`endif

// ---- shared/obc_pkg.sv ----
// types for the option bus controller
`default_nettype none
package obc_pkg;
  typedef enum logic [5:0] {
    OBC_IDLE  = 6'b000001,
    OBC_ALE   = 6'b000010,
    OBC_STRB  = 6'b000100,
    OBC_WAIT  = 6'b001000,
    OBC_DONE  = 6'b010000,
    OBC_GRANT = 6'b100000
  } obc_state_e;
  typedef struct packed {
    logic        valid;
    logic        is_mem;
    logic        write;
    logic        main_cpu;
    logic        refresh;
    logic        wide;
    logic [19:0] addr;
    logic        locked;
  } obc_req_s;
endpackage
`default_nettype wire

// ---- tb/obc_board_model.sv ----
// behavioural option board: bus requests, wait stretching, parity faults
`default_nettype none
module obc_board_model (
  input  wire logic       clock,
  input  wire logic [3:0] want,
  input  wire logic [2:0] wait_len,
  input  wire logic       pfail,
  input  wire logic       mem_read_strobe_n,
  input  wire logic       mem_write_strobe_n,
  output logic [3:0]      bus_master_request_n,
  output logic            wait_line_n,
  output logic            parity_error_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_reg;
  wire logic  strb = !(mem_read_strobe_n && mem_write_strobe_n);
  // request is a level; dropping it is how the board hands the bus back
  assign bus_master_request_n = ~want;
  // released wait floats to its pull-up, never to the last driven value
  assign wait_line_n = !(strb && cnt_reg < {1'b0, wait_len});
  assign parity_error_n = ~pfail;
  always_ff @(posedge clock) begin
    cnt_reg <= strb ? cnt_reg + 4'h1 : 4'h0;
  end
endmodule
`default_nettype wire

// ---- tb/obc_ctrl_assertions.sv ----
// port assertions for the option bus controller
`default_nettype none
module obc_ctrl_assertions
  import obc_pkg::*;
(
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire obc_req_s    cpu_req,
  input wire logic        cpu_ready,
  input wire logic        wait_request_n_in,
  input wire logic        parity_error_n,
  input wire logic [3:0]  bus_master_request_n,
  input wire logic [3:0]  bus_master_grant_n,
  input wire logic        bus_owned,
  input wire logic [19:0] bus_address_line,
  input wire logic        mem_write_strobe_n,
  input wire logic        mem_read_strobe_n,
  input wire logic        mem_strobe_oe,
  input wire logic        io_write_strobe_n,
  input wire logic        io_read_strobe_n,
  input wire logic        mem_not_io_select,
  input wire logic        early_mem_cycle_trigger_n,
  input wire logic        address_latch_strobe,
  input wire logic        system_io_page_select_n,
  input wire logic        nmi
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  AST_ALE_PULSE: assert property (address_latch_strobe |=> !address_latch_strobe)
    else $error("latch strobe longer than one cycle");
  AST_ALE_MAIN: assert property (address_latch_strobe |-> cpu_req.main_cpu)
    else $error("latch strobe on a secondary cycle");
  AST_IO_MAIN: assert property (!(io_read_strobe_n && io_write_strobe_n) |-> cpu_req.main_cpu)
    else $error("io strobe without main processor");
  AST_MIO: assert property (address_latch_strobe |-> mem_not_io_select == cpu_req.is_mem ##1 $stable(mem_not_io_select))
    else $error("memory io select wrong or unstable");
  AST_SMC: assert property (!early_mem_cycle_trigger_n |-> mem_not_io_select)
    else $error("early trigger outside memory cycle");
  AST_SYSIO: assert property (!system_io_page_select_n |-> !mem_not_io_select && bus_address_line[15:10] == 6'h0)
    else $error("system io select misdecoded");
  AST_WR: assert property (!mem_write_strobe_n && mem_strobe_oe |-> cpu_req.is_mem && cpu_req.write)
    else $error("memory write strobe on wrong cycle");
  AST_RD: assert property (!mem_read_strobe_n && mem_strobe_oe |-> cpu_req.is_mem && !cpu_req.write)
    else $error("memory read strobe on wrong cycle");
  AST_SLOW_IO: assert property (address_latch_strobe && !cpu_req.is_mem && cpu_req.addr[19:8] == 12'h003
    && wait_request_n_in |-> ##1 !cpu_ready [*4] ##1 cpu_ready)
    else $error("slow io cycle without two waits");
  AST_GRANT_OFF: assert property (bus_master_request_n[0] |=> bus_master_grant_n[0])
    else $error("grant kept after request released");
  AST_GRANT_BUS: assert property (!(&bus_master_grant_n) |-> !bus_owned)
    else $error("main board drives bus while granted");
  AST_PFAIL: assert property (!parity_error_n |-> ##[0:2] nmi)
    else $error("no nmi after parity fail");
  AST_NMI_HOLD: assert property (nmi |=> nmi)
    else $error("nmi dropped before reset");
endmodule
bind obc_ctrl obc_ctrl_assertions i_obc_ctrl_assertions (.*);
`default_nettype wire

// ---- tb/obc_ctrl_test.sv ----
// self-checking bench for the option bus controller
`include "obc_map.svh"
`default_nettype none
module obc_ctrl_test
  import obc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 0, sys_rst = 1, reset_button = 0, key_reset_combo = 0, onboard_parity_err = 0, pfail = 0;
  logic        cpu_ready, bus_owned, bus_address_oe, upper_byte_lane_enable_n, mem_write_strobe_n, wcap;
  logic        mem_read_strobe_n, mem_strobe_oe, io_write_strobe_n, io_read_strobe_n, mem_not_io_select;
  logic        early_mem_cycle_trigger_n, address_latch_strobe, wait_request_n_out, wait_request_oe, nmi;
  logic        system_io_page_select_n, dram_refresh_cycle_n, parity_offboard, irq_valid, bus_clock, hsync_n;
  logic        serial_rate_clock, global_reset_n, dot_clock_n, character_clock_n, vsync_n, wait_line_n;
  logic        parity_error_n;
  logic [2:0]  wait_len = 0;
  logic [3:0]  want = 0, bus_master_request_n, bus_master_grant_n;
  logic [6:0]  expansion_irq_line_n = '1, seen;
  logic [7:0]  irq_vector, ra, pr;
  logic [19:0] bus_address_line, cap, a;
  logic [31:0] r;
  obc_req_s    cpu_req = '0;
  int          err_total = 0, tests_run = 0, cyc = 0, seed = 32'h19f8ab5b, lat, base_mem, base_io;
  wire logic   wait_request_n_in = wait_line_n & (wait_request_oe ? wait_request_n_out : 1'b1);
  wire logic [4:0] clks = {hsync_n, character_clock_n, bus_clock, serial_rate_clock, dot_clock_n};
  const logic [7:0]  vec [7] = '{8'h60, 8'h61, 8'h62, 8'h64, 8'h66, 8'h69, 8'h6b};
  const logic [19:0] cor [5] = '{20'h002ff, 20'h00300, 20'h00380, 20'h003ff, 20'h00400};

  obc_ctrl i_obc_ctrl (.*);
  obc_board_model i_obc_board_model (.*);

  always #2 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("mismatches %0d, checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  function automatic logic [6:0] exp_seen(input logic m, w, main, input logic [19:0] ad);
    return {main, m & w, m & !w, !m & w & main, !m & !w & main, m, !m && ad[15:10] == 6'h0};
  endfunction

  function automatic int exp_lat(input logic m, input logic [19:0] ad);
    return m ? base_mem : base_io + ((ad >= `OBC_SLOW_IO_LO && ad <= `OBC_SLOW_IO_HI) ? 2 : 0);
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic bus_cyc(input logic m, w, main, wide, input logic [19:0] ad, output int n);
    tick(1);
    cpu_req = '{1'b1, m, w, main, 1'b0, wide, ad, 1'b0};
    seen = '0;
    n = 0;
    // strobes are collected over the whole cycle, address and lane only at the latch strobe
    while (cpu_ready !== 1'b1 && n < 40) begin
      tick(1);
      n++;
      seen = seen | {address_latch_strobe, ~mem_write_strobe_n, ~mem_read_strobe_n, ~io_write_strobe_n,
                     ~io_read_strobe_n, ~early_mem_cycle_trigger_n, ~system_io_page_select_n};
      if (address_latch_strobe) begin
        cap = bus_address_line;
        wcap = ~upper_byte_lane_enable_n;
      end
    end
    cpu_req.valid = 1'b0;
    check(n < 40 && seen === exp_seen(m, w, main, ad), "cycle strobes wrong");
    if (main) check(cap === ad && wcap === (m & wide), "address or lane wrong");
  endtask

  task automatic do_reset();
    sys_rst = 1;
    tick(10);
    sys_rst = 0;
  endtask

  task automatic half(input int k, input int e);
    int n;
    // align to the start of a low phase, then time that phase
    for (int p = 0; p < 3; p++) begin
      n = 0;
      while (clks[k] === p[0] && n < 4000) begin
        tick(1);
        n++;
      end
    end
    check(n === e, "clock low phase wrong");
  endtask

  initial begin
    do_reset();
    check(global_reset_n === 1'b0, "bus reset not held");
    bus_cyc(1, 0, 1, 0, 20'h12345, base_mem);
    check(base_mem >= 4 && base_mem <= 6, "memory latency");
    bus_cyc(0, 0, 1, 0, 20'h00100, base_io);
    check(base_io === base_mem, "io latency");
    tick(70);
    check(vsync_n === 1'b0, "no frame sync at start");
    check(global_reset_n === 1'b1, "bus reset stuck");
    for (int i = 0; i < 10; i++) begin
      bus_cyc(0, i[0], 1, 0, cor[i / 2], lat);
      check(lat === exp_lat(0, cor[i / 2]), "io wait count");
    end
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      a = r[0] ? r[31:12] : {4'h0, r[2] ? 6'h0 : r[21:16], r[11:2]};
      bus_cyc(r[0], r[1], r[3], r[0] & r[4] & ~a[0], a, lat);
      check(lat === exp_lat(r[0], a), "random cycle latency");
    end
    for (int k = 1; k < 4; k++) begin
      wait_len = 3'(k);
      bus_cyc(1, 1, 1, 0, 20'h80000, lat);
      check(lat === base_mem + k, "wait not honoured");
    end
    wait_len = 0;
    for (int i = 0; i < 257; i++) begin
      pr = ra;
      cpu_req = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 20'h0, 1'b0};
      lat = 0;
      for (int c = 0; c < 12; c++) begin
        tick(1);
        if (dram_refresh_cycle_n === 1'b0) begin
          ra = bus_address_line[7:0];
          lat = 1;
          cpu_req.valid = 1'b0;
        end
      end
      check(lat == 1 && (i == 0 || ra === pr + 8'h1), "refresh address");
    end
    for (int i = 0; i < 4; i++) begin
      want = (4'h1 << i) | 4'h8;
      tick(10);
      check(bus_master_grant_n === ~(4'h1 << i) && bus_owned === 1'b0 && bus_address_oe === 1'b0, "grant wrong");
      want = 0;
      tick(3);
      check(bus_master_grant_n === 4'hf, "grant not withdrawn");
    end
    cpu_req = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 20'h01000, 1'b1};
    tick(2);
    want = 4'h2;
    tick(12);
    check(bus_master_grant_n === 4'hf && bus_owned === 1'b1, "grant inside locked sequence");
    for (int c = 0; c < 8 && cpu_ready !== 1'b1; c++) tick(1);
    cpu_req.valid = 1'b0;
    tick(2);
    check(bus_master_grant_n === 4'hd && bus_owned === 1'b0, "no grant after locked sequence");
    want = 0;
    tick(3);
    for (int i = 0; i < 7; i++) begin
      expansion_irq_line_n = ~((7'h1 << i) | 7'h40);
      tick(3);
      check(irq_valid === 1'b1 && irq_vector === vec[i], "irq vector");
    end
    expansion_irq_line_n = '1;
    tick(3);
    check(irq_valid === 1'b0, "irq with no line");
    half(2, `OBC_BUS_CLK_HALF);
    half(1, `OBC_BAUD_HALF);
    half(0, `OBC_DOT_HALF);
    half(3, 2 * `OBC_DOT_HALF * (`OBC_CHAR_DOTS >> 1));
    half(4, 2 * `OBC_DOT_HALF * `OBC_CHAR_DOTS * `OBC_HSYNC_WIDTH);
    for (int p = 0; p < 2; p++) begin
      {key_reset_combo, reset_button} = 2'b01 << p;
      tick(3);
      {key_reset_combo, reset_button} = 2'b00;
      tick(2);
      check(global_reset_n === 1'b0, "reset source ignored");
      tick(70);
      check(global_reset_n === 1'b1, "bus reset stuck");
    end
    onboard_parity_err = 1;
    tick(2);
    onboard_parity_err = 0;
    tick(2);
    check(nmi === 1'b1 && parity_offboard === 1'b0, "onboard parity");
    do_reset();
    check(nmi === 1'b0, "nmi survives reset");
    pfail = 1;
    tick(3);
    pfail = 0;
    check(nmi === 1'b1 && parity_offboard === 1'b1, "bus parity");
    complete_run();
  end
endmodule
`default_nettype wire
